// *** rtl/rss_consts.svh ***
// constants for the reciprocal seed sequencer
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// register byte offsets
`define RSS_ADDR_CTRL      4'h0
`define RSS_ADDR_OPERAND   4'h4
`define RSS_ADDR_STATUS    4'h8
`define RSS_ADDR_RESULT    4'hc

// field positions
`define RSS_CTRL_START     0
`define RSS_CTRL_FORMAT    1
`define RSS_ITER_LSB       4
`define RSS_ITER_MSB       7
`define RSS_STAT_BUSY      0
`define RSS_STAT_DONE      1

// iteration count values: reset value, clear value and step
`define RSS_ITERS_RESET    4'h2
`define RSS_ITERS_ZERO     4'h0
`define RSS_ITERS_ONE      4'h1

// operation select codes driven to the arithmetic unit
`define RSS_OP_MULTIPLY    3'h2
`define RSS_OP_TWO_MINUS   3'h4

// seed look-up table geometry
`define RSS_EXP_ENTRIES    512
`define RSS_FRAC_ENTRIES   4096
`define RSS_FRAC_ONE       65536
`define RSS_FRAC_ALL_ONES  16'hffff
`define RSS_EXP_NO_SEED    8'h00
`define RSS_LEGACY_BIAS    257
`define RSS_IEEE_BIAS      253
`define RSS_LEGACY_MIN_EXP 2
`define RSS_IEEE_MAX_EXP   252
`define RSS_FRAC_LOW_ZERO  7'h00

`endif

// *** rtl/rss_pkg.sv ***
// types shared by the reciprocal seed sequencer
`include "rss_consts.svh"

package rss_pkg;

  typedef enum logic [2:0] {
    RSS_IDLE = 3'b000,
    RSS_SEED = 3'b001,
    RSS_PROD = 3'b010,
    RSS_TWOM = 3'b011,
    RSS_MULF = 3'b100,
    RSS_NEWX = 3'b101
  } rss_state_t;

  typedef struct packed {
    rss_state_t  st;
    logic [3:0]  iters;
    logic [3:0]  iter_cnt;
    logic        fmt;
    logic        done;
    logic [31:0] operand;
    logic [31:0] result;
    logic [31:0] r_bus;
    logic [31:0] s_bus;
    logic [2:0]  op;
    logic        s_fb;
    logic        r_fb;
    logic        enr_n;
    logic        ens_n;
    logic        enf_n;
    logic        wait_req;
    logic [31:0] rdata;
  } rss_regs_t;

endpackage

// *** rtl/rss_seed_if.sv ***
// carrier between the sequencer and its seed look-up table
`timescale 1ns/1ps
`default_nettype none

interface rss_seed_if;
  logic [31:0] operand;
  logic        format_select;
  logic [31:0] seed;

  modport lut (input operand, input format_select, output seed);
  modport user (output operand, output format_select, input seed);
endinterface

`default_nettype wire

// *** rtl/rss_seed_lut.sv ***
// seed look-up table: exponent and fraction tables built at elaboration
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.svh"

module rss_seed_lut (
  rss_seed_if.lut sif
);

  logic [7:0]  exp_rom  [0:`RSS_EXP_ENTRIES-1];
  logic [15:0] frac_rom [0:`RSS_FRAC_ENTRIES-1];

  // =====================================================
  // table contents
  // =====================================================
  function automatic logic [7:0] exp_entry(input int idx);
    int e;
    int v;
    e = idx % 256;
    v = 0;
    if (idx >= 256) begin
      // too-small reciprocals hold a zero marker
      if (e <= `RSS_IEEE_MAX_EXP) begin
        v = `RSS_IEEE_BIAS - e;
      end
    end else if (e >= `RSS_LEGACY_MIN_EXP) begin
      v = `RSS_LEGACY_BIAS - e;
    end
    return v[7:0];
  endfunction

  function automatic logic [15:0] frac_entry(input int i);
    int v;
    if (i == 0) begin
      return `RSS_FRAC_ALL_ONES;
    end
    // round((4096-i)/(4096+i) * 65536), which is 2/(1+f)-1 scaled
    v = (2 * `RSS_FRAC_ONE * (`RSS_FRAC_ENTRIES - i) + (`RSS_FRAC_ENTRIES + i))
        / (2 * (`RSS_FRAC_ENTRIES + i));
    return v[15:0];
  endfunction

  genvar g;
  generate
    for (g = 0; g < `RSS_EXP_ENTRIES; g++) begin : g_exp
      assign exp_rom[g] = exp_entry(g);
    end
    for (g = 0; g < `RSS_FRAC_ENTRIES; g++) begin : g_frac
      assign frac_rom[g] = frac_entry(g);
    end
  endgenerate

  // =====================================================
  // seed assembly
  // =====================================================
  // sign copied; exponent section picked by format; fraction table shared
  assign sif.seed = {sif.operand[31],
                     exp_rom[{sif.format_select, sif.operand[30:23]}],
                     frac_rom[sif.operand[22:11]],
                     `RSS_FRAC_LOW_ZERO};

endmodule

`default_nettype wire

// *** rtl/rss_sequencer.sv ***
// reciprocal seed sequencer: register slave, seed path and step controller
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.svh"

module rss_sequencer (
  input  wire  logic        ref_clk,
  input  wire  logic        rst_n,
  input  wire  logic [3:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [31:0] avs_writedata,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  input  wire  logic [31:0] f_bus_in,
  output logic [31:0]       r_bus_out,
  output logic [31:0]       s_bus_out,
  output logic [2:0]        operation_select,
  output logic              s_port_feedback_select,
  output logic              r_path_feedback_select,
  output logic              r_input_load_enable_n,
  output logic              s_input_load_enable_n,
  output logic              result_load_enable_n,
  output logic              format_select
);

  rss_pkg::rss_regs_t q;
  rss_pkg::rss_regs_t d;
  rss_seed_if         sif ();

  // =====================================================
  // seed look-up
  // =====================================================
  assign sif.operand       = q.operand;
  // a start write may change the format in the same access, and the seed of
  // cycle 1 is taken at that very edge, so the new section is looked up directly
  assign sif.format_select = (avs_write && !q.wait_req && q.st == rss_pkg::RSS_IDLE
                              && avs_address == `RSS_ADDR_CTRL)
                             ? avs_writedata[`RSS_CTRL_FORMAT] : q.fmt;

  rss_seed_lut u_lut (
    .sif (sif)
  );

  // =====================================================
  // next state
  // =====================================================
  always_comb begin
    logic req;
    logic acc;
    logic start;
    req   = 1'b0;
    acc   = 1'b0;
    start = 1'b0;
    d = q;
    d.wait_req = 1'b1;
    req = avs_read | avs_write;
    // one wait cycle, then the access completes
    if (req && q.wait_req) begin
      d.wait_req = 1'b0;
      d.rdata = 32'h0000_0000;
      if (avs_address == `RSS_ADDR_CTRL) begin
        d.rdata[`RSS_CTRL_FORMAT] = q.fmt;
        d.rdata[`RSS_ITER_MSB:`RSS_ITER_LSB] = q.iters;
      end else if (avs_address == `RSS_ADDR_OPERAND) begin
        d.rdata = q.operand;
      end else if (avs_address == `RSS_ADDR_STATUS) begin
        d.rdata[`RSS_STAT_BUSY] = (q.st != rss_pkg::RSS_IDLE);
        d.rdata[`RSS_STAT_DONE] = q.done;
        d.rdata[`RSS_ITER_MSB:`RSS_ITER_LSB] = q.iter_cnt;
      end else if (avs_address == `RSS_ADDR_RESULT) begin
        d.rdata = q.result;
      end
    end
    acc = avs_write && !q.wait_req;
    // operand and format are frozen while a sequence runs
    if (acc && q.st == rss_pkg::RSS_IDLE) begin
      if (avs_address == `RSS_ADDR_CTRL) begin
        d.fmt   = avs_writedata[`RSS_CTRL_FORMAT];
        d.iters = avs_writedata[`RSS_ITER_MSB:`RSS_ITER_LSB];
        start   = avs_writedata[`RSS_CTRL_START];
      end else if (avs_address == `RSS_ADDR_OPERAND) begin
        d.operand = avs_writedata;
      end
    end
    if (acc && avs_address == `RSS_ADDR_STATUS && avs_writedata[`RSS_STAT_DONE]) begin
      d.done = 1'b0;
    end

    case (q.st)
      rss_pkg::RSS_IDLE: begin
        if (start) begin
          d.st       = rss_pkg::RSS_SEED;
          d.iter_cnt = `RSS_ITERS_ZERO;
          d.done     = 1'b0;
        end
      end
      rss_pkg::RSS_SEED: begin
        d.st = rss_pkg::RSS_PROD;
      end
      rss_pkg::RSS_PROD: begin
        d.st = rss_pkg::RSS_TWOM;
      end
      rss_pkg::RSS_TWOM: begin
        d.st = rss_pkg::RSS_MULF;
      end
      rss_pkg::RSS_MULF: begin
        d.st = rss_pkg::RSS_NEWX;
      end
      rss_pkg::RSS_NEWX: begin
        // the result register now holds the new estimate
        d.iter_cnt = q.iter_cnt + `RSS_ITERS_ONE;
        d.result   = f_bus_in;
        if (d.iter_cnt >= q.iters) begin
          d.st   = rss_pkg::RSS_IDLE;
          d.done = 1'b1; // set wins over a same-cycle clear
        end else begin
          d.st = rss_pkg::RSS_TWOM;
        end
      end
      default: begin
        d.st = rss_pkg::RSS_IDLE;
      end
    endcase

    // =====================================================
    // control lines, decoded from the coming state
    // =====================================================
    // decoding from d keeps every pin a flop yet still aligned to its cycle
    d.s_bus = q.operand;
    d.r_bus = q.operand;
    d.op    = `RSS_OP_MULTIPLY;
    d.s_fb  = 1'b0;
    d.r_fb  = 1'b0;
    d.enr_n = 1'b1;
    d.ens_n = 1'b1;
    d.enf_n = 1'b1;
    case (d.st)
      rss_pkg::RSS_SEED: begin
        d.r_bus = sif.seed;
        d.enr_n = 1'b0;
        d.ens_n = 1'b0;
      end
      rss_pkg::RSS_PROD: begin
        d.op    = `RSS_OP_MULTIPLY;
        d.s_fb  = 1'b0;
        d.enf_n = 1'b0;
      end
      rss_pkg::RSS_TWOM: begin
        d.op    = `RSS_OP_TWO_MINUS;
        d.s_fb  = 1'b1;
        d.enf_n = 1'b0;
      end
      rss_pkg::RSS_MULF: begin
        d.op    = `RSS_OP_MULTIPLY;
        d.s_fb  = 1'b1;
        d.r_fb  = 1'b1;
        d.enr_n = 1'b0;
        d.enf_n = 1'b0;
      end
      rss_pkg::RSS_NEWX: begin
        d.op    = `RSS_OP_MULTIPLY;
        d.s_fb  = 1'b0;
        d.enf_n = 1'b0;
      end
      default: begin
        d.op = `RSS_OP_MULTIPLY;
      end
    endcase
  end

  // =====================================================
  // state register
  // =====================================================
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q          <= '0;
      q.st       <= rss_pkg::RSS_IDLE;
      q.iters    <= `RSS_ITERS_RESET;
      q.op       <= `RSS_OP_MULTIPLY;
      q.enr_n    <= 1'b1;
      q.ens_n    <= 1'b1;
      q.enf_n    <= 1'b1;
      q.wait_req <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata           = q.rdata;
  assign avs_waitrequest        = q.wait_req;
  assign r_bus_out              = q.r_bus;
  assign s_bus_out              = q.s_bus;
  assign operation_select       = q.op;
  assign s_port_feedback_select = q.s_fb;
  assign r_path_feedback_select = q.r_fb;
  assign r_input_load_enable_n  = q.enr_n;
  assign s_input_load_enable_n  = q.ens_n;
  assign result_load_enable_n   = q.enf_n;
  assign format_select          = q.fmt;

endmodule

`default_nettype wire

// *** verif/rss_fpu_model.sv ***
// behavioural processor: r, s and f registers with a toy alu
`timescale 1ns/1ps
`default_nettype none
module rss_fpu_model (
  input  wire logic        clk,
  input  wire logic [31:0] r_bus,
  input  wire logic [31:0] s_bus,
  input  wire logic [2:0]  op,
  input  wire logic        sfb,
  input  wire logic        rfb,
  input  wire logic        enr_n,
  input  wire logic        ens_n,
  input  wire logic        enf_n,
  output logic [31:0]      f_q
);
  // ==========
  // integer product stands in for the float unit; wraps at 32 bits
  logic [31:0] r_q;
  logic [31:0] s_q;
  logic [31:0] sp;
  logic [31:0] alu;
  assign sp = sfb ? f_q : s_q;
  assign alu = (op == 3'h4) ? 32'h2 - sp : r_q * sp;
  initial f_q = 32'h0;
  always @(posedge clk) begin
    if (!ens_n) s_q <= s_bus;
    if (!enr_n) r_q <= rfb ? alu : r_bus;
    if (!enf_n) f_q <= alu;
  end
endmodule
`default_nettype wire

// *** verif/rss_sequencer_sva.sv ***
// port assertions for the sequencer
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_sva (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] r_bus_out,
  input wire logic [31:0] s_bus_out,
  input wire logic [2:0]  operation_select,
  input wire logic        s_port_feedback_select,
  input wire logic        r_path_feedback_select,
  input wire logic        r_input_load_enable_n,
  input wire logic        s_input_load_enable_n,
  input wire logic        result_load_enable_n,
  input wire logic        format_select
);
  // ==========
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_c1; !s_input_load_enable_n; endsequence
  sequence s_tm; operation_select == 3'h4; endsequence
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait");
  chk_step_one: assert property (s_c1 |-> !r_input_load_enable_n && result_load_enable_n
    && operation_select == 3'h2) else $error("step1");
  chk_step_two: assert property (s_c1 |=> r_input_load_enable_n && s_input_load_enable_n
    && !result_load_enable_n && operation_select == 3'h2 && !s_port_feedback_select) else $error("s2");
  chk_iter_start: assert property (s_c1 ##2 1 |-> s_tm) else $error("iter");
  chk_two_minus: assert property (s_tm |-> s_port_feedback_select && !result_load_enable_n
    && r_input_load_enable_n) else $error("step3");
  chk_step_four: assert property (s_tm |=> operation_select == 3'h2 && s_port_feedback_select
    && r_path_feedback_select && !r_input_load_enable_n) else $error("step4");
  chk_step_five: assert property (s_tm ##1 1 |=> operation_select == 3'h2
    && !s_port_feedback_select && r_input_load_enable_n && !result_load_enable_n) else $error("s5");
  chk_seed_low: assert property (s_c1 |-> r_bus_out[31] == s_bus_out[31]
    && r_bus_out[6:0] == 7'h0) else $error("seed");
  chk_frac_zero: assert property (!s_input_load_enable_n && s_bus_out[22:11] == 12'h0
    |-> r_bus_out[22:7] == 16'hffff) else $error("frac");
  chk_ieee_exp: assert property (!s_input_load_enable_n && format_select
    && s_bus_out[30:23] < 8'hfd
    |-> r_bus_out[30:23] == 8'(9'd253 - s_bus_out[30:23])) else $error("ieee");
  chk_legacy_exp: assert property (!s_input_load_enable_n && !format_select
    && s_bus_out[30:23] > 8'h01
    |-> r_bus_out[30:23] == 8'(9'd257 - s_bus_out[30:23])) else $error("legacy");
endmodule
bind rss_sequencer rss_sequencer_sva chk (.*);
`default_nettype wire

// *** verif/rss_sequencer_test.sv ***
// self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_test;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, sfb, rfb, enr_n, ens_n, enf_n, fmt;
  logic [3:0] avs_address;
  logic [2:0] op;
  logic [31:0] avs_writedata, avs_readdata, f_bus, r_bus, s_bus, seed_seen, q;
  int num_errors = 0;
  int comparisons = 0;
  int nf;
  rss_sequencer uut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .f_bus_in(f_bus), .r_bus_out(r_bus), .s_bus_out(s_bus),
    .operation_select(op), .s_port_feedback_select(sfb), .r_path_feedback_select(rfb),
    .r_input_load_enable_n(enr_n), .s_input_load_enable_n(ens_n),
    .result_load_enable_n(enf_n), .format_select(fmt));
  rss_fpu_model fpu (.clk(ref_clk), .r_bus, .s_bus, .op, .sfb, .rfb, .enr_n, .ens_n, .enf_n,
    .f_q(f_bus));
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (ens_n === 1'b0) seed_seen = r_bus;
    if (enf_n === 1'b0) nf++;
  end
  // ==========
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
    q = avs_readdata;
    if (n == 50) num_errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function automatic logic [31:0] seed(input logic [31:0] b, input logic ieee);
    int e, i, fr;
    e = b[30:23];
    i = b[22:11];
    e = ieee ? (e > 252 ? 0 : 253 - e) : (e < 2 ? 0 : 257 - e);
    fr = (i == 0) ? 'hffff : (131072 * (4096 - i) + 4096 + i) / (2 * (4096 + i));
    return {b[31], e[7:0], fr[15:0], 7'h0};
  endfunction
  task automatic run(input logic [31:0] b, input logic ieee, input int n);
    logic [31:0] x;
    int k;
    nf = 0;
    bus(1'b1, 4'h4, b);
    bus(1'b1, 4'h0, {24'h0, 4'(n), 2'b0, ieee, 1'b1});
    k = 0;
    do bus(1'b0, 4'h8, 32'h0); while (q[0] !== 1'b0 && ++k < 100);
    if (n == 0) n = 1;
    chk({26'h0, q[7:4], q[1:0]}, {26'h0, 4'(n), 2'b10});
    x = seed(b, ieee);
    chk(seed_seen, x);
    chk(32'(nf), 32'(1 + 3 * n));
    for (k = 0; k < n; k++) x = x * (32'h2 - x * b);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, x);
    bus(1'b1, 4'h8, 32'h2);
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #3000000;
    num_errors++;
    finish_test;
  end
  initial begin
    ref_clk = 0;
    rst_n = 0;
    avs_address = 0;
    avs_read = 0;
    avs_write = 0;
    avs_writedata = 0;
    void'($urandom(32'he74c5a7c));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk({27'h0, enr_n, ens_n, enf_n, avs_waitrequest, fmt}, 32'h1e);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    run(32'h41ca6666, 1'b1, 1);
    run(32'hbef1eb85, 1'b1, 2);
    run(32'h00800000, 1'b0, 0);
    run(32'h7e800000, 1'b1, 3);
    run(32'h3f800000, 1'b0, 2);
    repeat (8) run($urandom, 1'($urandom), $urandom_range(0, 3));
    finish_test;
  end
endmodule
`default_nettype wire
